/* logic/ppi_regs.sv */
// pad pull inhibit register bank with avalon-mm slave
//
// Register access over Avalon-MM was left to the implementer.
`timescale 1ns/1ns
`include "ppi_map.svh"

// Notes on behaviour
// - bits 14,13 inhibit irq1/irq0 pull-ups
// - bit 12 inhibits reset pin pull-up
// - bit 11 inhibits both emulation pull-ups
// - bits 10,9,8 inhibit tdi, tms, tck pull-ups
// - pull-up bit 0 on, 1 off
// - bits 5..0 inhibit address pins 20..15 pull-downs
// - pull-down bit 0 on, 1 off
// - parallel register bits 15..2 read/write, reset 1
// - parallel bit n inhibits pin n pull-down
module ppi_regs (
  input wire logic ref_clk_in,
  input wire logic rst_in,
  input wire logic [17:0] address_in,
  input wire logic read_in,
  input wire logic write_in,
  input wire logic [31:0] writedata_in,
  input wire logic [3:0] byteenable_in,
  output logic [31:0] readdata_out,
  output logic [1:0] response_out,
  output logic waitrequest_out,
  output logic irq1_pullup_off_out,
  output logic irq0_pullup_off_out,
  output logic rst_pin_pullup_off_out,
  output logic emulation_pin_zero_pullup_off_out,
  output logic emulation_pin_one_pullup_off_out,
  output logic test_data_in_pullup_off_out,
  output logic test_mode_sel_pullup_off_out,
  output logic test_clock_pullup_off_out,
  output logic [20:15] addr_pulldown_off_out,
  output logic [15:2] par_pulldown_off_out
);

  ppi_pkg::ppi_state_t s;
  ppi_pkg::ppi_state_t next_s;
  logic req;
  logic accept;
  logic hit_misc;
  logic hit_par;

  // byte-lane merge restricted to the writable bits of a register
  function automatic logic [15:0] merge(input logic [15:0] old, input logic [31:0] wd,
                                        input logic [3:0] be, input logic [15:0] mask);
    logic [15:0] lanes;
    lanes = {{8{be[1]}}, {8{be[0]}}} & mask;
    merge = (old & ~lanes) | (wd[15:0] & lanes);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // bus decode: one wait cycle, then the answer edge
  assign req = read_in | write_in;
  assign accept = req & ~s.wait_n;
  assign hit_misc = (address_in[17:2] == `PPI_MISC_IDX) && (address_in[1:0] == 2'h0);
  assign hit_par = (address_in[17:2] == `PPI_PAR_IDX) && (address_in[1:0] == 2'h0);

  always_comb begin
    next_s = s;
    next_s.wait_n = 1'b1;
    if (req && s.wait_n) begin
      next_s.wait_n = 1'b0;
      next_s.resp = (hit_misc || hit_par) ? `PPI_RESP_OKAY : `PPI_RESP_DECERR;
      next_s.rdata = 32'h0000_0000;
      if (read_in && hit_misc) begin
        next_s.rdata = {16'h0000, s.misc & `PPI_MISC_MASK};
      end
      if (read_in && hit_par) begin
        next_s.rdata = {16'h0000, s.par & `PPI_PAR_MASK};
      end
    end
    if (accept && write_in && hit_misc) begin
      next_s.misc = merge(s.misc, writedata_in, byteenable_in, `PPI_MISC_MASK);
    end
    if (accept && write_in && hit_par) begin
      next_s.par = merge(s.par, writedata_in, byteenable_in, `PPI_PAR_MASK);
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      s.wait_n <= 1'b1;
      s.misc <= `PPI_MISC_RESET;
      s.par <= `PPI_PAR_RESET;
      s.rdata <= 32'h0000_0000;
      s.resp <= `PPI_RESP_OKAY;
    end else begin
      s <= next_s;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs straight from the state flops; 1 switches the resistor off
  assign readdata_out = s.rdata;
  assign response_out = s.resp;
  assign waitrequest_out = s.wait_n;
  assign irq1_pullup_off_out = s.misc[`PPI_IRQ1_BIT];
  assign irq0_pullup_off_out = s.misc[`PPI_IRQ0_BIT];
  assign rst_pin_pullup_off_out = s.misc[`PPI_RST_BIT];
  assign emulation_pin_zero_pullup_off_out = s.misc[`PPI_EMU_BIT];
  assign emulation_pin_one_pullup_off_out = s.misc[`PPI_EMU_BIT];
  assign test_data_in_pullup_off_out = s.misc[`PPI_TDI_BIT];
  assign test_mode_sel_pullup_off_out = s.misc[`PPI_TMS_BIT];
  assign test_clock_pullup_off_out = s.misc[`PPI_TCK_BIT];
  assign addr_pulldown_off_out = s.misc[`PPI_ADDR_MSB:`PPI_ADDR_LSB];
  assign par_pulldown_off_out = s.par[`PPI_PAR_MSB:`PPI_PAR_LSB];

  ////////////////////////////////////////////////////////////////////////////
  // checks
  logic wr_misc_hi;
  logic wr_misc_lo;
  logic wr_par_hi;
  logic wr_par_lo;
  assign wr_misc_hi = accept & write_in & hit_misc & byteenable_in[1];
  assign wr_misc_lo = accept & write_in & hit_misc & byteenable_in[0];
  assign wr_par_hi = accept & write_in & hit_par & byteenable_in[1];
  assign wr_par_lo = accept & write_in & hit_par & byteenable_in[0];

  property p_irq_pullups;
    @(posedge ref_clk_in) disable iff (rst_in)
    wr_misc_hi |=> irq1_pullup_off_out == $past(writedata_in[14])
      && irq0_pullup_off_out == $past(writedata_in[13]);
  endproperty
  a_irq_pullups: assert property (p_irq_pullups) else $error("irq pull-up inhibit wrong");

  property p_rst_pullup;
    @(posedge ref_clk_in) disable iff (rst_in)
    wr_misc_hi |=> rst_pin_pullup_off_out == $past(writedata_in[12]);
  endproperty
  a_rst_pullup: assert property (p_rst_pullup) else $error("reset pull-up inhibit wrong");

  property p_emu_pullup;
    @(posedge ref_clk_in) disable iff (rst_in)
    wr_misc_hi |=> emulation_pin_zero_pullup_off_out == $past(writedata_in[11])
      && emulation_pin_one_pullup_off_out == $past(writedata_in[11]);
  endproperty
  a_emu_pullup: assert property (p_emu_pullup) else $error("emulation pull-up wrong");

  property p_test_pullups;
    @(posedge ref_clk_in) disable iff (rst_in)
    wr_misc_hi |=> {test_data_in_pullup_off_out, test_mode_sel_pullup_off_out,
      test_clock_pullup_off_out} == $past(writedata_in[10:8]);
  endproperty
  a_test_pullups: assert property (p_test_pullups) else $error("test pin pull-up wrong");

  property p_pullup_hold;
    @(posedge ref_clk_in) disable iff (rst_in)
    !wr_misc_hi |=> $stable(irq1_pullup_off_out) && $stable(rst_pin_pullup_off_out);
  endproperty
  a_pullup_hold: assert property (p_pullup_hold) else $error("pull-up inhibit changed");

  property p_addr_pulldowns;
    @(posedge ref_clk_in) disable iff (rst_in)
    wr_misc_lo |=> addr_pulldown_off_out == $past(writedata_in[5:0]);
  endproperty
  a_addr_pulldowns: assert property (p_addr_pulldowns) else $error("address pull-down wrong");

  property p_par_pulldowns;
    @(posedge ref_clk_in) disable iff (rst_in)
    wr_par_lo && wr_par_hi |=> par_pulldown_off_out == $past(writedata_in[15:2]);
  endproperty
  a_par_pulldowns: assert property (p_par_pulldowns) else $error("parallel pull-down wrong");

  property p_par_lane;
    @(posedge ref_clk_in) disable iff (rst_in)
    wr_par_lo && !wr_par_hi |=> par_pulldown_off_out[15:8] == $past(par_pulldown_off_out[15:8])
      && par_pulldown_off_out[7:2] == $past(writedata_in[7:2]);
  endproperty
  a_par_lane: assert property (p_par_lane) else $error("parallel lane write wrong");

  property p_par_readback;
    @(posedge ref_clk_in) disable iff (rst_in)
    req && s.wait_n && read_in && hit_par
      |=> readdata_out == {16'h0000, $past(par_pulldown_off_out), 2'b00} && !waitrequest_out;
  endproperty
  a_par_readback: assert property (p_par_readback) else $error("parallel readback wrong");

  property p_reserved_zero;
    @(posedge ref_clk_in) disable iff (rst_in)
    !waitrequest_out && read_in |-> readdata_out[31:16] == 16'h0000
      && (!hit_misc || (readdata_out[15] == 1'b0 && readdata_out[7:6] == 2'b00))
      && (!hit_par || readdata_out[1:0] == 2'b00);
  endproperty
  a_reserved_zero: assert property (p_reserved_zero) else $error("reserved bits not zero");

  property p_answer_time;
    @(posedge ref_clk_in) disable iff (rst_in)
    req && waitrequest_out |=> !waitrequest_out ##1 waitrequest_out;
  endproperty
  a_answer_time: assert property (p_answer_time) else $error("bus answer timing wrong");

  ////////////////////////////////////////////////////////////////////////////
  // further checks on holding, decode and reset
  property p_test_hold;
    @(posedge ref_clk_in) disable iff (rst_in)
    !wr_misc_hi
      |=> $stable(test_data_in_pullup_off_out) && $stable(test_clock_pullup_off_out);
  endproperty
  a_test_hold: assert property (p_test_hold) else $error("test pin pull-up changed");

  property p_emu_hold;
    @(posedge ref_clk_in) disable iff (rst_in)
    !wr_misc_hi
      |=> $stable(test_mode_sel_pullup_off_out) && $stable(emulation_pin_zero_pullup_off_out);
  endproperty
  a_emu_hold: assert property (p_emu_hold) else $error("emulation pull-up changed");

  property p_addr_hold;
    @(posedge ref_clk_in) disable iff (rst_in)
    !wr_misc_lo
      |=> $stable(addr_pulldown_off_out);
  endproperty
  a_addr_hold: assert property (p_addr_hold) else $error("address pull-down changed");

  property p_par_hold;
    @(posedge ref_clk_in) disable iff (rst_in)
    !(wr_par_lo || wr_par_hi)
      |=> $stable(par_pulldown_off_out);
  endproperty
  a_par_hold: assert property (p_par_hold) else $error("parallel pull-down changed");

  property p_par_hi_lane;
    @(posedge ref_clk_in) disable iff (rst_in)
    wr_par_hi && !wr_par_lo |=> par_pulldown_off_out[7:2] == $past(par_pulldown_off_out[7:2])
      && par_pulldown_off_out[15:8] == $past(writedata_in[15:8]);
  endproperty
  a_par_hi_lane: assert property (p_par_hi_lane) else $error("parallel high lane wrong");

  property p_decode_error;
    @(posedge ref_clk_in) disable iff (rst_in)
    req && s.wait_n && !hit_misc && !hit_par
      |=> response_out == `PPI_RESP_DECERR;
  endproperty
  a_decode_error: assert property (p_decode_error) else $error("unmapped response wrong");

  property p_decode_okay;
    @(posedge ref_clk_in) disable iff (rst_in)
    req && s.wait_n && (hit_misc || hit_par)
      |=> response_out == `PPI_RESP_OKAY;
  endproperty
  a_decode_okay: assert property (p_decode_okay) else $error("mapped response wrong");

  property p_misc_readback;
    @(posedge ref_clk_in) disable iff (rst_in)
    req && s.wait_n && read_in && hit_misc |=> readdata_out[14:8] == $past({irq1_pullup_off_out,
      irq0_pullup_off_out, rst_pin_pullup_off_out, emulation_pin_zero_pullup_off_out,
      test_data_in_pullup_off_out, test_mode_sel_pullup_off_out, test_clock_pullup_off_out})
      && readdata_out[5:0] == $past(addr_pulldown_off_out);
  endproperty
  a_misc_readback: assert property (p_misc_readback) else $error("misc readback wrong");

  property p_unmapped_zero;
    @(posedge ref_clk_in) disable iff (rst_in)
    req && s.wait_n && read_in && !hit_misc && !hit_par
      |=> readdata_out == 32'h0000_0000;
  endproperty
  a_unmapped_zero: assert property (p_unmapped_zero) else $error("unmapped read not zero");

  property p_write_rdata;
    @(posedge ref_clk_in) disable iff (rst_in)
    req && s.wait_n && write_in
      |=> readdata_out == 32'h0000_0000;
  endproperty
  a_write_rdata: assert property (p_write_rdata) else $error("write answer data not zero");

  property p_wait_idle;
    @(posedge ref_clk_in) disable iff (rst_in)
    !req && waitrequest_out
      |=> waitrequest_out;
  endproperty
  a_wait_idle: assert property (p_wait_idle) else $error("answer without request");

  property p_wait_single;
    @(posedge ref_clk_in) disable iff (rst_in)
    !waitrequest_out
      |=> waitrequest_out;
  endproperty
  a_wait_single: assert property (p_wait_single) else $error("answer longer than a cycle");

  property p_read_no_write;
    @(posedge ref_clk_in) disable iff (rst_in)
    read_in
      |=> $stable(par_pulldown_off_out) && $stable(addr_pulldown_off_out);
  endproperty
  a_read_no_write: assert property (p_read_no_write) else $error("read changed a register");

  // reset is the antecedent here, so these two carry no disable
  property p_reset_pins;
    @(posedge ref_clk_in)
    rst_in |=> par_pulldown_off_out == 14'h3fff && addr_pulldown_off_out == 6'h00
      && irq1_pullup_off_out && irq0_pullup_off_out && !rst_pin_pullup_off_out;
  endproperty
  a_reset_pins: assert property (p_reset_pins) else $error("pin reset levels wrong");

  property p_reset_bus;
    @(posedge ref_clk_in)
    rst_in |=> waitrequest_out && response_out == `PPI_RESP_OKAY
      && readdata_out == 32'h0000_0000;
  endproperty
  a_reset_bus: assert property (p_reset_bus) else $error("bus reset state wrong");

endmodule

/* logic/ppi_map.svh */
// register indices, field positions and reset values of the pad pull inhibit bank
`ifndef PPI_MAP_SVH
`define PPI_MAP_SVH
`define PPI_MISC_IDX 16'h1C18
`define PPI_PAR_IDX 16'h1C19
`define PPI_MISC_RESET 16'h6000
`define PPI_PAR_RESET 16'hFFFC
`define PPI_MISC_MASK 16'h7F3F
`define PPI_PAR_MASK 16'hFFFC
`define PPI_IRQ1_BIT 14
`define PPI_IRQ0_BIT 13
`define PPI_RST_BIT 12
`define PPI_EMU_BIT 11
`define PPI_TDI_BIT 10
`define PPI_TMS_BIT 9
`define PPI_TCK_BIT 8
`define PPI_ADDR_LSB 0
`define PPI_ADDR_MSB 5
`define PPI_PAR_LSB 2
`define PPI_PAR_MSB 15
`define PPI_RESP_OKAY 2'h0
`define PPI_RESP_DECERR 2'h3
`endif

/* logic/ppi_pkg.sv */
// types of the pad pull inhibit bank
package ppi_pkg;
  typedef struct packed {
    logic wait_n;
    logic [15:0] misc;
    logic [15:0] par;
    logic [31:0] rdata;
    logic [1:0] resp;
  } ppi_state_t;
endpackage

/* test/ppi_regs_tb.sv */
// self-checking testbench for the pad pull inhibit register bank
`timescale 1ns/1ns
`include "ppi_map.svh"
module testbench;
  localparam logic [17:0] misc_a = {`PPI_MISC_IDX, 2'b00};
  localparam logic [17:0] par_a = {`PPI_PAR_IDX, 2'b00};
  logic ref_clk_in, rst_in, read_in, write_in, waitrequest_out;
  logic irq1, irq0, rstp, emulation_pin_zero, emulation_pin_one, tdi, tms, tck;
  logic [17:0] address_in;
  logic [31:0] writedata_in, readdata_out;
  logic [3:0] byteenable_in;
  logic [1:0] response_out;
  logic [20:15] addr_pd;
  logic [15:2] par_pd;
  logic [15:0] m, p;
  logic [18:0] q[$];
  logic [17:0] tbl[4];
  logic [31:0] r;
  logic [31:0] rq;
  int fails, tests_run;
  ppi_regs dut (.ref_clk_in(ref_clk_in), .rst_in(rst_in), .address_in(address_in),
    .read_in(read_in), .write_in(write_in), .writedata_in(writedata_in),
    .byteenable_in(byteenable_in), .readdata_out(readdata_out), .response_out(response_out),
    .waitrequest_out(waitrequest_out), .irq1_pullup_off_out(irq1), .irq0_pullup_off_out(irq0),
    .rst_pin_pullup_off_out(rstp), .emulation_pin_zero_pullup_off_out(emulation_pin_zero),
    .emulation_pin_one_pullup_off_out(emulation_pin_one), .test_data_in_pullup_off_out(tdi),
    .test_mode_sel_pullup_off_out(tms), .test_clock_pullup_off_out(tck),
    .addr_pulldown_off_out(addr_pd), .par_pulldown_off_out(par_pd));
  ////////////////////////////////////////////////////////////////////////////////
  task automatic end_sim;
    if (fails == 0 && tests_run > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  task automatic chk_bus(input logic [33:0] got, input logic [33:0] exp);
    tests_run++;
    if (got !== exp) begin
      fails++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic chk_pins();
    tests_run++;
    if ({irq1, irq0, rstp, emulation_pin_zero, emulation_pin_one, tdi, tms, tck, addr_pd, par_pd} !==
        {m[14:11], m[11], m[10:8], m[5:0], p[15:2]}) begin
      fails++;
      $display("[FAIL] %0t got %h exp %h", $time,
        {irq1, irq0, rstp, emulation_pin_zero, emulation_pin_one, tdi, tms, tck, addr_pd, par_pd},
        {m[14:11], m[11], m[10:8], m[5:0], p[15:2]});
    end
  endtask
  // one bus access; the expected answer is queued for the monitor
  task automatic acc(input logic wr, input logic [17:0] a, input logic [15:0] d,
      input logic [1:0] be);
    logic [15:0] bm, ex;
    logic [1:0] rsp;
    int n;
    bm = {{8{be[1]}}, {8{be[0]}}};
    rsp = `PPI_RESP_OKAY;
    ex = 16'h0000;
    if (a == misc_a) ex = m;
    else if (a == par_a) ex = p;
    else rsp = `PPI_RESP_DECERR;
    if (wr && a == misc_a) m = ((m & ~bm) | (d & bm)) & 16'h7f3f;
    if (wr && a == par_a) p = ((p & ~bm) | (d & bm)) & 16'hfffc;
    q.push_back({wr, rsp, ex});
    @(posedge ref_clk_in);
    read_in <= !wr;
    write_in <= wr;
    address_in <= a;
    writedata_in <= {~d, d};
    byteenable_in <= {~be, be};
    n = 0;
    do begin
      @(posedge ref_clk_in);
      n++;
    end while (waitrequest_out !== 1'b0 && n < 16);
    if (waitrequest_out !== 1'b0) begin
      fails++;
      end_sim();
    end
    read_in <= 1'b0;
    write_in <= 1'b0;
    @(negedge ref_clk_in);
    chk_pins();
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  always @(posedge ref_clk_in) begin
    if ((read_in || write_in) && waitrequest_out === 1'b0) begin
      if (q.size() == 0) begin
        fails++;
      end else begin
        rq = {13'h0000, q.pop_front()};
        chk_bus({response_out, rq[18] ? 32'h0000_0000 : readdata_out},
          {rq[17:16], 16'h0000, rq[18] ? 16'h0000 : rq[15:0]});
      end
    end
  end
  initial begin
    ref_clk_in = 1'b0;
    forever #10 ref_clk_in = ~ref_clk_in;
  end
  initial begin
    {read_in, write_in, address_in, writedata_in, byteenable_in} = '0;
    rst_in = 1'b1;
    tbl = '{misc_a, par_a, 18'h0_7068, 18'h0_7061};
    void'($urandom(32'ha1a9_674c));
    m = 16'h6000;
    p = 16'hfffc;
    repeat (2) @(posedge ref_clk_in);
    rst_in <= 1'b0;
    acc(1'b0, misc_a, 16'h0000, 2'b11);
    acc(1'b0, par_a, 16'h0000, 2'b11);
    // walking one through every bit of misc and walking zero through every bit of par
    for (int i = 0; i < 16; i++) begin
      acc(1'b1, misc_a, 16'h0001 << i, 2'b11);
      acc(1'b1, par_a, ~(16'h0001 << i), 2'b11);
      acc(1'b0, misc_a, 16'h0000, 2'b11);
    end
    for (int i = 0; i < 40; i++) begin
      r = $urandom;
      acc(r[2], tbl[r[1:0]], r[31:16], r[4:3]);
    end
    acc(1'b0, par_a, 16'h0000, 2'b11);
    if (q.size() != 0) fails++;
    end_sim();
  end
endmodule
